// [asp_driver_model.sv]
// Motor driver model counting steps and pulse spacing
`timescale 1ns/1ns
module asp_driver_model (
  input wire logic sys_clk,
  input wire logic clr,
  input wire logic pulse,
  input wire logic dir,
  output int steps,
  output int position,
  output int min_gap,
  output int max_gap
);
  // ----------------------------------------------------------------
  // Step counting
  // ----------------------------------------------------------------
  int since;
  always @(posedge sys_clk) begin
    if (clr) begin
      steps <= 0;
      position <= 0;
      min_gap <= 1 << 30;
      max_gap <= 0;
      since <= 0;
    end else if (pulse) begin
      // Direction is taken with each step, high means negative travel
      position <= dir ? position - 1 : position + 1;
      steps <= steps + 1;
      since <= 1;
      if (steps > 0) begin
        min_gap <= since < min_gap ? since : min_gap;
        max_gap <= since > max_gap ? since : max_gap;
      end
    end else begin
      since <= since + 1;
    end
  end
endmodule

// [asp_pkg.sv]
// Shared constants and types for the axis speed profile generator
package asp_pkg;

  // ----------------------------------------------------------------
  // Register command indices
  // ----------------------------------------------------------------
  localparam logic [3:0] ASP_REG_AMOUNT = 4'h0;
  localparam logic [3:0] ASP_REG_START = 4'h1;
  localparam logic [3:0] ASP_REG_RUN = 4'h2;
  localparam logic [3:0] ASP_REG_ACCEL = 4'h3;
  localparam logic [3:0] ASP_REG_DECEL = 4'h4;
  localparam logic [3:0] ASP_REG_SCALE = 4'h5;
  localparam logic [3:0] ASP_REG_DOWN = 4'h6;
  localparam logic [3:0] ASP_REG_ASPAN = 4'h7;
  localparam logic [3:0] ASP_REG_DSPAN = 4'h8;
  localparam logic [3:0] ASP_REG_MODE = 4'h9;
  localparam logic [3:0] ASP_REG_STATUS = 4'hA;
  localparam logic [3:0] ASP_REG_SPEED = 4'hB;
  localparam logic [3:0] ASP_REG_REMAIN = 4'hC;

  // ----------------------------------------------------------------
  // Field widths and positions
  // ----------------------------------------------------------------
  localparam int ASP_AMOUNT_W = 28;
  localparam int ASP_SPEED_W = 16;
  localparam int ASP_RATE_W = 16;
  localparam int ASP_SCALE_W = 12;
  localparam int ASP_DOWN_W = 24;
  localparam int ASP_SPAN_W = 15;
  localparam int ASP_MODE_CURVE_BIT = 0;
  localparam int ASP_MODE_MANUAL_BIT = 1;
  localparam int ASP_MODE_RAMP_BIT = 2;
  localparam int ASP_MODE_W = 3;
  localparam int ASP_FRAC_BITS = 16;

  // ----------------------------------------------------------------
  // Timing and reset values
  // ----------------------------------------------------------------
  localparam int ASP_LIN_SHIFT = 2;
  localparam int ASP_SCURVE_SHIFT = 3;
  localparam int ASP_TICK_W = 20;
  localparam logic [11:0] ASP_SCALE_RESET = 12'h002;
  localparam logic [15:0] ASP_SPEED_RESET = 16'h0001;
  localparam logic [15:0] ASP_RATE_RESET = 16'h0001;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    ASP_IDLE = 5'b00001,
    ASP_ACCEL = 5'b00010,
    ASP_CRUISE = 5'b00100,
    ASP_DECEL = 5'b01000,
    ASP_FEED = 5'b10000
  } asp_state_t;

  typedef struct packed {
    logic [ASP_AMOUNT_W-1:0] amount;
    logic [ASP_SPEED_W-1:0] start_speed;
    logic [ASP_SPEED_W-1:0] run_speed;
    logic [ASP_RATE_W-1:0] accel_rate;
    logic [ASP_RATE_W-1:0] decel_rate;
    logic [ASP_SCALE_W-1:0] speed_scale;
    logic [ASP_DOWN_W-1:0] ramp_down_point;
    logic [ASP_SPAN_W-1:0] accel_span;
    logic [ASP_SPAN_W-1:0] decel_span;
    logic [ASP_MODE_W-1:0] mode;
  } asp_prof_t;

  typedef struct packed {
    logic en;
    logic [3:0] sel;
    logic [31:0] data;
  } asp_wr_t;

endpackage

// [asp_profile.sv]
// Axis speed profile generator: pre-registers, ramp engine and pulse output
// Function
// - Positioning amount is a 28-bit signed count, full range accepted.
// - Start speed is the constant low rate and the ramp start rate.
// - Linear acceleration takes speed difference times (accel+1) times 4 clocks.
// - Pure S-curve acceleration takes speed difference times (accel+1) times 8 clocks.
// - S-curve with span takes (difference plus twice span) times (accel+1) times 4.
// - Zero deceleration rate means the acceleration rate is used instead.
// - Deceleration time mirrors acceleration with the deceleration settings.
// - Speed scale of 12 bits sets unit to clock over (scale+1) times 65536.
// - Manual mode decelerates once remaining count is at most the ramp-down value.
// - Automatic mode treats ramp-down value as signed offset to computed point.
// - S-curve shaping within accel span near both speeds, linear between.
// - Zero acceleration span is replaced by half the speed difference.
// - Separate deceleration span shapes deceleration; zero means half the difference.
// - Late ramp-down stops above start speed; early one feeds at start speed.
`timescale 1ns/1ns
module asp_profile #(
  parameter int AMOUNT_W = 28,
  parameter logic [11:0] SCALE_RESET = 12'h002
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire asp_pkg::asp_wr_t wr,
  input wire logic [3:0] rd_sel,
  input wire logic start_move,
  output logic [31:0] rd_data,
  output logic pulse_out,
  output logic dir_out,
  output logic busy_out
);
  import asp_pkg::*;

  asp_prof_t pre_q;
  asp_prof_t act_q;
  asp_state_t state_q;
  asp_state_t state_d;
  logic [ASP_SPEED_W-1:0] speed_q;
  logic [ASP_TICK_W-1:0] tick_q;
  logic [AMOUNT_W-1:0] remain_q;
  logic [AMOUNT_W-1:0] accel_pulses_q;
  logic dir_q;
  logic busy_q;
  logic gen_pulse;

  // ----------------------------------------------------------------
  // Pre-register writes
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pre_q <= '0;
      pre_q.start_speed <= ASP_SPEED_RESET;
      pre_q.run_speed <= ASP_SPEED_RESET;
      pre_q.accel_rate <= ASP_RATE_RESET;
      pre_q.speed_scale <= SCALE_RESET;
    end else if (ce && wr.en) begin
      if (wr.sel == ASP_REG_AMOUNT) begin
        pre_q.amount <= wr.data[ASP_AMOUNT_W-1:0];
      end else if (wr.sel == ASP_REG_START) begin
        pre_q.start_speed <= wr.data[ASP_SPEED_W-1:0];
      end else if (wr.sel == ASP_REG_RUN) begin
        pre_q.run_speed <= wr.data[ASP_SPEED_W-1:0];
      end else if (wr.sel == ASP_REG_ACCEL) begin
        pre_q.accel_rate <= wr.data[ASP_RATE_W-1:0];
      end else if (wr.sel == ASP_REG_DECEL) begin
        pre_q.decel_rate <= wr.data[ASP_RATE_W-1:0];
      end else if (wr.sel == ASP_REG_SCALE) begin
        pre_q.speed_scale <= wr.data[ASP_SCALE_W-1:0];
      end else if (wr.sel == ASP_REG_DOWN) begin
        pre_q.ramp_down_point <= wr.data[ASP_DOWN_W-1:0];
      end else if (wr.sel == ASP_REG_ASPAN) begin
        pre_q.accel_span <= wr.data[ASP_SPAN_W-1:0];
      end else if (wr.sel == ASP_REG_DSPAN) begin
        pre_q.decel_span <= wr.data[ASP_SPAN_W-1:0];
      end else if (wr.sel == ASP_REG_MODE) begin
        pre_q.mode <= wr.data[ASP_MODE_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Working copies
  // ----------------------------------------------------------------
  // Host may stage the next move while this one runs
  logic move_go;
  assign move_go = start_move && (state_q == ASP_IDLE);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      act_q <= '0;
      act_q.speed_scale <= SCALE_RESET;
    end else if (ce && move_go) begin
      act_q <= pre_q;
    end
  end

  // ----------------------------------------------------------------
  // Derived ramp quantities
  // ----------------------------------------------------------------
  logic [ASP_SPEED_W-1:0] diff;
  logic [ASP_SPEED_W-1:0] aspan;
  logic [ASP_SPEED_W-1:0] dspan;
  logic [ASP_RATE_W-1:0] drate;
  logic curve;
  logic manual;
  logic ramped;
  logic a_zone;
  logic d_zone;
  logic [ASP_TICK_W-1:0] step_lim;
  logic step;
  logic signed [AMOUNT_W+1:0] auto_point;
  logic signed [AMOUNT_W+1:0] remain_s;
  logic rd_hit;

  always_comb begin
    curve = act_q.mode[ASP_MODE_CURVE_BIT];
    manual = act_q.mode[ASP_MODE_MANUAL_BIT];
    ramped = act_q.mode[ASP_MODE_RAMP_BIT];
    diff = (act_q.run_speed > act_q.start_speed) ?
           (act_q.run_speed - act_q.start_speed) : '0;
    // Zero span gives an S-curve with no linear middle
    aspan = (act_q.accel_span == '0) ? (diff >> 1) :
            ASP_SPEED_W'(act_q.accel_span);
    dspan = (act_q.decel_span == '0) ? (diff >> 1) :
            ASP_SPEED_W'(act_q.decel_span);
    drate = (act_q.decel_rate == '0) ? act_q.accel_rate : act_q.decel_rate;
    // Each speed unit inside a span costs twice the linear step time
    a_zone = curve && ((speed_q < act_q.start_speed + aspan) ||
             (speed_q >= act_q.run_speed - aspan));
    d_zone = curve && ((speed_q > act_q.run_speed - dspan) ||
             (speed_q <= act_q.start_speed + dspan));
    if (state_q == ASP_DECEL) begin
      step_lim = ASP_TICK_W'({1'b0, drate} + 17'h00001) <<
                 (d_zone ? ASP_SCURVE_SHIFT : ASP_LIN_SHIFT);
    end else begin
      step_lim = ASP_TICK_W'({1'b0, act_q.accel_rate} + 17'h00001) <<
                 (a_zone ? ASP_SCURVE_SHIFT : ASP_LIN_SHIFT);
    end
    step = (tick_q + 1'b1 >= step_lim);
    // Automatic point is the pulses spent accelerating plus a signed offset
    auto_point = $signed({2'b00, accel_pulses_q}) +
                 (AMOUNT_W+2)'($signed(act_q.ramp_down_point));
    remain_s = $signed({2'b00, remain_q});
    if (manual) begin
      rd_hit = ({{(AMOUNT_W-ASP_DOWN_W){1'b0}}, act_q.ramp_down_point} >= remain_q);
    end else begin
      rd_hit = (remain_s <= auto_point) ||
               (remain_s <= $signed({2'b00, accel_pulses_q}) && state_q == ASP_ACCEL);
    end
  end

  // ----------------------------------------------------------------
  // Profile state machine
  // ----------------------------------------------------------------
  logic last_pulse;
  assign last_pulse = gen_pulse && (remain_q == AMOUNT_W'(1));

  always_comb begin
    state_d = state_q;
    case (state_q)
      ASP_IDLE: begin
        if (move_go) begin
          if (pre_q.amount == '0) begin
            state_d = ASP_IDLE;
          end else if (pre_q.mode[ASP_MODE_RAMP_BIT] &&
                       pre_q.run_speed > pre_q.start_speed) begin
            state_d = ASP_ACCEL;
          end else begin
            state_d = ASP_FEED;
          end
        end
      end
      ASP_ACCEL: begin
        if (rd_hit) begin
          state_d = ASP_DECEL;
        end else if (step && speed_q + 1'b1 >= act_q.run_speed) begin
          state_d = ASP_CRUISE;
        end
      end
      ASP_CRUISE: begin
        if (rd_hit) begin
          state_d = ASP_DECEL;
        end
      end
      ASP_DECEL: begin
        if (step && speed_q <= act_q.start_speed + 1'b1) begin
          state_d = ASP_FEED;
        end
      end
      ASP_FEED: begin
        state_d = ASP_FEED;
      end
      default: begin
        state_d = ASP_IDLE;
      end
    endcase
    // Count exhausted ends the move at whatever speed is current
    if (state_q != ASP_IDLE && last_pulse) begin
      state_d = ASP_IDLE;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= ASP_IDLE;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Speed and ramp step timer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tick_q <= '0;
    end else if (ce) begin
      if (state_q != state_d || step ||
          (state_q != ASP_ACCEL && state_q != ASP_DECEL)) begin
        tick_q <= '0;
      end else begin
        tick_q <= tick_q + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      speed_q <= '0;
    end else if (ce) begin
      if (state_d == ASP_IDLE) begin
        speed_q <= '0;
      end else if (state_q == ASP_IDLE) begin
        speed_q <= pre_q.start_speed;
      end else if (state_q == ASP_ACCEL && step && speed_q < act_q.run_speed) begin
        speed_q <= speed_q + 1'b1;
      end else if (state_q == ASP_DECEL && step && speed_q > act_q.start_speed) begin
        speed_q <= speed_q - 1'b1;
      end else if (state_q == ASP_FEED) begin
        speed_q <= act_q.start_speed;
      end
    end
  end

  // ----------------------------------------------------------------
  // Position bookkeeping
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      remain_q <= '0;
      dir_q <= 1'b0;
    end else if (ce) begin
      if (move_go) begin
        // Magnitude of a 28-bit signed amount always fits in 28 bits unsigned
        remain_q <= pre_q.amount[AMOUNT_W-1] ? (~pre_q.amount + 1'b1) : pre_q.amount;
        dir_q <= pre_q.amount[AMOUNT_W-1];
      end else if (gen_pulse && remain_q != '0) begin
        remain_q <= remain_q - 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      accel_pulses_q <= '0;
    end else if (ce) begin
      if (move_go) begin
        accel_pulses_q <= '0;
      end else if (state_q == ASP_ACCEL && gen_pulse) begin
        accel_pulses_q <= accel_pulses_q + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      busy_q <= 1'b0;
    end else if (ce) begin
      busy_q <= (state_d != ASP_IDLE);
    end
  end

  // ----------------------------------------------------------------
  // Pulse generator
  // ----------------------------------------------------------------
  asp_pulse_gen #(
    .SPEED_W(ASP_SPEED_W),
    .SCALE_W(ASP_SCALE_W)
  ) u_pulse_gen (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .run(busy_q),
    .speed(speed_q),
    .scale(act_q.speed_scale),
    .pulse(gen_pulse)
  );

  assign pulse_out = gen_pulse;
  assign dir_out = dir_q;
  assign busy_out = busy_q;

  // ----------------------------------------------------------------
  // Register read-back
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_data <= '0;
    end else if (ce) begin
      if (rd_sel == ASP_REG_AMOUNT) begin
        rd_data <= {{(32-ASP_AMOUNT_W){pre_q.amount[ASP_AMOUNT_W-1]}}, pre_q.amount};
      end else if (rd_sel == ASP_REG_START) begin
        rd_data <= {16'h0000, pre_q.start_speed};
      end else if (rd_sel == ASP_REG_RUN) begin
        rd_data <= {16'h0000, pre_q.run_speed};
      end else if (rd_sel == ASP_REG_ACCEL) begin
        rd_data <= {16'h0000, pre_q.accel_rate};
      end else if (rd_sel == ASP_REG_DECEL) begin
        rd_data <= {16'h0000, pre_q.decel_rate};
      end else if (rd_sel == ASP_REG_SCALE) begin
        rd_data <= {20'h00000, pre_q.speed_scale};
      end else if (rd_sel == ASP_REG_DOWN) begin
        rd_data <= {8'h00, pre_q.ramp_down_point};
      end else if (rd_sel == ASP_REG_ASPAN) begin
        rd_data <= {17'h00000, pre_q.accel_span};
      end else if (rd_sel == ASP_REG_DSPAN) begin
        rd_data <= {17'h00000, pre_q.decel_span};
      end else if (rd_sel == ASP_REG_MODE) begin
        rd_data <= {29'h00000000, pre_q.mode};
      end else if (rd_sel == ASP_REG_STATUS) begin
        rd_data <= {26'h0000000, dir_q, state_q};
      end else if (rd_sel == ASP_REG_SPEED) begin
        rd_data <= {16'h0000, speed_q};
      end else if (rd_sel == ASP_REG_REMAIN) begin
        rd_data <= {{(32-AMOUNT_W){1'b0}}, remain_q};
      end else begin
        rd_data <= '0;
      end
    end
  end

endmodule

// [asp_profile_asserts.sv]
// Port-level assertions for the axis speed profile generator
`timescale 1ns/1ns
module asp_profile_asserts
  import asp_pkg::*;
#(
  parameter int AMOUNT_W = 28
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire asp_pkg::asp_wr_t wr,
  input wire logic [3:0] rd_sel,
  input wire logic start_move,
  input wire logic [31:0] rd_data,
  input wire logic pulse_out,
  input wire logic dir_out,
  input wire logic busy_out
);
  // ----------------------------------------------------------------
  // Shadow of the amount pre-register and checks
  // ----------------------------------------------------------------
  logic [AMOUNT_W-1:0] amt_q;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      amt_q <= '0;
    end else if (ce && wr.en && wr.sel == ASP_REG_AMOUNT) begin
      amt_q <= wr.data[AMOUNT_W-1:0];
    end
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  AST_START_BUSY: assert property (ce && start_move && !busy_out
    |=> busy_out == ($past(amt_q) != '0))
    else $error("busy does not follow a taken start");
  AST_DIR_SIGN: assert property (ce && start_move && !busy_out && amt_q != '0
    |=> dir_out == $past(amt_q[AMOUNT_W-1]))
    else $error("direction does not match amount sign");
  AST_DIR_HOLD: assert property (busy_out && $past(busy_out) |-> $stable(dir_out))
    else $error("direction changed in mid-move");
  AST_PULSE_IN_MOVE: assert property (pulse_out |-> busy_out)
    else $error("pulse outside a move");
  AST_PULSE_GAP: assert property (pulse_out && ce |=> !pulse_out)
    else $error("pulses on adjacent cycles");
  AST_BUSY_END: assert property ($fell(busy_out) |-> $past(pulse_out))
    else $error("busy fell without a last pulse");
  AST_UNMAPPED: assert property (ce && rd_sel > ASP_REG_REMAIN |=> rd_data == '0)
    else $error("unmapped read not zero");
  AST_AMT_SEXT: assert property (ce && rd_sel == ASP_REG_AMOUNT
    |=> rd_data[31:28] == {4{rd_data[27]}})
    else $error("amount read not sign extended");
  AST_STATUS_ONEHOT: assert property (ce && rd_sel == ASP_REG_STATUS
    |=> $onehot(rd_data[4:0]))
    else $error("status state not one-hot");
  AST_WR_READBACK: assert property (ce && wr.en && wr.sel == ASP_REG_RUN ##1
    ce && rd_sel == ASP_REG_RUN && !wr.en |=> rd_data[15:0] == $past(wr.data[15:0], 2))
    else $error("run speed readback wrong");
  cover property ($fell(busy_out));
  cover property (ce && start_move && busy_out);
  cover property (ce && rd_sel == ASP_REG_STATUS ##1 rd_data[4:0] == 5'h10);
endmodule

bind asp_profile asp_profile_asserts #(.AMOUNT_W(AMOUNT_W)) u_asserts (
  .sys_clk(sys_clk), .rst(rst), .ce(ce), .wr(wr), .rd_sel(rd_sel),
  .start_move(start_move), .rd_data(rd_data), .pulse_out(pulse_out),
  .dir_out(dir_out), .busy_out(busy_out)
);

// [asp_pulse_gen.sv]
// Rate accumulator turning a speed value into an output pulse train
`timescale 1ns/1ns
module asp_pulse_gen #(
  parameter int SPEED_W = 16,
  parameter int SCALE_W = 12
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic run,
  input wire logic [SPEED_W-1:0] speed,
  input wire logic [SCALE_W-1:0] scale,
  output logic pulse
);
  import asp_pkg::*;

  localparam int ACC_W = SCALE_W + ASP_FRAC_BITS + 1;

  logic [ACC_W-1:0] acc_q;
  logic [ACC_W-1:0] acc_sum;
  logic [ACC_W-1:0] div_val;
  logic wrap;

  // ----------------------------------------------------------------
  // Divider and accumulator
  // ----------------------------------------------------------------
  always_comb begin
    div_val = ACC_W'({1'b0, scale} + 13'h0001) << ASP_FRAC_BITS;
    acc_sum = acc_q + ACC_W'(speed);
    wrap = (acc_sum >= div_val);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      acc_q <= '0;
    end else if (ce) begin
      if (!run) begin
        acc_q <= '0;
      end else if (wrap) begin
        acc_q <= acc_sum - div_val;
      end else begin
        acc_q <= acc_sum;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pulse <= 1'b0;
    end else if (ce) begin
      pulse <= run && wrap;
    end
  end

endmodule

// [test_axis_speed_profile_generator.sv]
// Self-checking bench for the axis speed profile generator
`timescale 1ns/1ns
module test_axis_speed_profile_generator;
  import asp_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus, expectations and sequence
  // ----------------------------------------------------------------
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  asp_wr_t wr = '0;
  logic [3:0] rd_sel = 4'h0;
  logic start_move = 1'b0;
  logic clr = 1'b1;
  logic [31:0] rd_data;
  logic pulse_out;
  logic dir_out;
  logic busy_out;
  int steps, position, min_gap, max_gap;
  int n_mismatch = 0;
  int tests_run = 0;
  logic [31:0] seed = 32'h0000D782;
  logic [31:0] pre [10];
  always #5 sys_clk = ~sys_clk;
  asp_profile dut (.sys_clk(sys_clk), .rst(rst), .ce(ce), .wr(wr), .rd_sel(rd_sel),
    .start_move(start_move), .rd_data(rd_data), .pulse_out(pulse_out), .dir_out(dir_out),
    .busy_out(busy_out));
  asp_driver_model drv (.sys_clk(sys_clk), .clr(clr), .pulse(pulse_out), .dir(dir_out),
    .steps(steps), .position(position), .min_gap(min_gap), .max_gap(max_gap));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [31:0] fmask(int i);
    case (i)
      0: return 32'h0FFFFFFF;
      5: return 32'h00000FFF;
      6: return 32'h00FFFFFF;
      7, 8: return 32'h00007FFF;
      9: return 32'h00000007;
      default: return 32'h0000FFFF;
    endcase
  endfunction
  function automatic int ramp_cyc(logic s, int diff, int span, int rate);
    if (!s) return diff * (rate + 1) * 4;
    if (span == 0) return diff * (rate + 1) * 8;
    return (diff + 2 * span) * (rate + 1) * 4;
  endfunction
  // Scale fixed at 2 in every move, hence the divisor of 3
  function automatic int rampdn_opt(int lo, int hi, int span, int rate);
    longint num;
    num = longint'(hi + lo) * (hi - lo + 2 * span) * (rate + 1);
    if (span == 0) num = num * 2;
    return int'(num / (3 * 32768));
  endfunction
  // Triangle start with the run speed never reached
  function automatic int tri_rampdn(int amt, int acc, int dec);
    return amt * (dec + 1) / (acc + dec + 2);
  endfunction
  task automatic summarize();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  // Ramp step phase makes a few cycles of slack unavoidable
  task automatic check_near(string name, int seen, int exp);
    check(name, 32'((seen - exp <= 8 && exp - seen <= 8) ? exp : seen), 32'(exp));
  endtask
  task automatic wr_reg(logic [3:0] sel, logic [31:0] d, logic c);
    wr = '{en: 1'b1, sel: sel, data: d};
    rd_sel = sel;
    ce = c;
    @(posedge sys_clk);
    #1;
    wr.en = 1'b0;
    ce = 1'b1;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic rd_reg(logic [3:0] sel, output logic [31:0] v);
    rd_sel = sel;
    @(posedge sys_clk);
    #1;
    v = rd_data;
  endtask
  task automatic setup(logic [2:0] md, int lo, int hi, int acc, int dec, int asp, int dsp,
      int rampdn, int amt);
    logic [31:0] v [10];
    v = '{amt, lo, hi, acc, dec, 2, rampdn, asp, dsp, md};
    for (int i = 0; i < 10; i++) wr_reg(4'(i), v[i], 1'b1);
  endtask
  // A refused start and a new amount are slipped in at cycle 3 of every move that raises busy
  task automatic move(int amt, int exp_acc, int exp_dec);
    int acc;
    int dec;
    int k;
    acc = 0;
    dec = 0;
    clr = 1'b1;
    rd_sel = ASP_REG_STATUS;
    start_move = 1'b1;
    @(posedge sys_clk);
    #1;
    clr = 1'b0;
    start_move = 1'b0;
    check("busy_on_start", {31'h0, busy_out}, 32'(amt != 0));
    for (k = 0; k < 40000 && busy_out === 1'b1; k++) begin
      start_move = (k == 3);
      wr = '{en: (k == 3), sel: ASP_REG_AMOUNT, data: 32'd9};
      @(posedge sys_clk);
      #1;
      acc += (rd_data[4:0] === 5'h02);
      dec += (rd_data[4:0] === 5'h08);
    end
    if (k == 40000) begin
      n_mismatch++;
      summarize();
    end
    check("steps", 32'(steps), 32'(amt < 0 ? -amt : amt));
    check("position", 32'(position), 32'(amt));
    if (exp_acc >= 0) check_near("accel_cycles", acc, exp_acc);
    if (exp_dec >= 0) check_near("decel_cycles", dec, exp_dec);
  endtask
  initial begin
    logic [31:0] v;
    logic [31:0] d;
    int i;
    repeat (20) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    pre = '{0, 1, 1, 1, 0, 2, 0, 0, 0, 0};
    for (int j = 0; j < 16; j++) begin
      rd_reg(4'(j), v);
      check("reset_value", v, j < 10 ? pre[j] : 32'(j == 10));
    end
    wr_reg(ASP_REG_AMOUNT, 32'h08000000, 1'b1);
    rd_reg(ASP_REG_AMOUNT, v);
    check("amount_min", v, 32'hF8000000);
    pre[0] = 32'h08000000;
    for (int n = 0; n < 30; n++) begin
      i = xs() % 10;
      d = xs();
      if (i inside {1, 2, 3, 5} && (d & fmask(i)) < 32'd2) d = d | 32'd2;
      wr_reg(4'(i), d, xs() > 32'h40000000);
      if (seed > 32'h40000000) pre[i] = d;
    end
    for (int j = 0; j < 10; j++) begin
      rd_reg(4'(j), v);
      check("readback", v, j == 0 ? {{4{pre[0][27]}}, pre[0][27:0]} : pre[j] & fmask(j));
    end
    setup(3'b000, 32768, 32768, 1, 0, 0, 0, 0, -7);
    move(-7, -1, -1);
    check("min_gap", 32'(min_gap), 32'd6);
    check("max_gap", 32'(max_gap), 32'd6);
    move(9, -1, -1);
    wr_reg(ASP_REG_AMOUNT, 32'h0, 1'b1);
    move(0, -1, -1);
    setup(3'b100, 32000, 32500, 1, 0, 0, 0, 20, 3000);
    move(3000, ramp_cyc(0, 500, 0, 1), ramp_cyc(0, 500, 0, 1));
    setup(3'b101, 32000, 32500, 1, 0, 0, 0, 20, 3000);
    move(3000, ramp_cyc(1, 500, 0, 1), ramp_cyc(1, 500, 0, 1));
    setup(3'b111, 32000, 32500, 1, 3, 0, 100, rampdn_opt(32000, 32500, 100, 3) + 20, 4000);
    move(4000, ramp_cyc(1, 500, 0, 1), ramp_cyc(1, 500, 100, 3));
    setup(3'b111, 32000, 32500, 1, 0, 100, 0, rampdn_opt(32000, 32500, 0, 1) + 20, 3000);
    move(3000, ramp_cyc(1, 500, 100, 1), ramp_cyc(1, 500, 0, 1));
    setup(3'b110, 32000, 32500, 1, 1, 0, 0, tri_rampdn(600, 1, 1), 600);
    move(600, -1, -1);
    summarize();
  end
endmodule
